/* logic/mfl_pkg.sv */
package mfl_pkg;
    // Times in their own units, cycles derived at 250 MHz
    localparam int CLK_MHZ      = 250;
    localparam int REGEN_US     = 5000;
    localparam int EN_LOW_NS    = 200000;
    localparam int ON_DELAY_NS  = 4000;
    localparam int REGEN_CYC    = REGEN_US * CLK_MHZ;
    localparam int EN_LOW_CYC   = (EN_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int ON_DELAY_CYC = (ON_DELAY_NS * CLK_MHZ) / 1000;
    localparam int CNT_W        = 21;
    localparam int SYNC_W       = 3;
    localparam logic [SYNC_W-1:0] SYNC_RST = 3'h0;
    localparam logic [SYNC_W-1:0] SYNC_RST_HI = 3'h7;

    typedef enum logic [1:0] {
        MFL_ST_OFF   = 2'b00,
        MFL_ST_DELAY = 2'b01,
        MFL_ST_ON    = 2'b10,
        MFL_ST_REGEN = 2'b11
    } mfl_state_e;

    // Conditioned inputs travel together
    typedef struct packed {
        logic over_temp_shutdown;
        logic overcurrent_shutdown;
        logic enable;
        logic standby_n_input;
    } mfl_in_s;

    // Bridge mode presented to the output stage
    typedef struct packed {
        logic drive_on;
        logic regen;
        logic hiz;
    } mfl_bridge_s;
endpackage

/* logic/mfl_ctrl.sv */
`timescale 1ns/100ps
// Overview of operation
// (R1) Over-temperature latches fault, flag low, shut down
// (R2) Over-temperature: regenerate 5 ms, then high impedance
// (R3) Latch clears after comparator low, enable low 0.2ms
// (R4) Release during enable low; flag rises then
// (R5) Bridge turns on 4 us after enable rises
// (R6) Any shutdown fault regenerates before high impedance
// (R7) Standby falling with enable high regenerates first
// (R8) Enable falling regenerates before high impedance
module mfl_ctrl #(
    parameter int REGEN_CYCLES = mfl_pkg::REGEN_CYC,
    parameter int EN_LOW_CYCLES = mfl_pkg::EN_LOW_CYC
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Pins from the host and the analogue comparators
    input  wire logic over_temp_shutdown_i,
    input  wire logic overcurrent_shutdown_i,
    input  wire logic enable_i,
    input  wire logic standby_n_input_i,
    // Open-drain fault flag
    output logic      fault_flag_output_o,
    output logic      fault_flag_output_oe_o,
    // Bridge control
    output logic      bridge_on_o,
    output logic      bridge_regen_o,
    output logic      bridge_hiz_o
);
    localparam int W = mfl_pkg::CNT_W;
    localparam logic [W-1:0] REGEN_END = W'(REGEN_CYCLES - 1);
    localparam logic [W-1:0] ENLOW_END = W'(EN_LOW_CYCLES - 1);
    localparam logic [W-1:0] DLY_END = W'(mfl_pkg::ON_DELAY_CYC - 1);

    // Three-stage synchronisers; decisions use stages 2 and 3 agreeing
    logic [mfl_pkg::SYNC_W-1:0] sy [4];
    logic [3:0] raw;
    mfl_pkg::mfl_in_s cin, next_cin;
    assign raw = {over_temp_shutdown_i, overcurrent_shutdown_i,
                  enable_i, standby_n_input_i};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    sy[g] <= (g == 0) ? mfl_pkg::SYNC_RST_HI
                                      : mfl_pkg::SYNC_RST;
                end else begin
                    sy[g] <= {sy[g][1:0], raw[g]};
                end
            end
        end
    endgenerate

    function automatic logic settle(input logic [2:0] s, input logic old);
        settle = (s[1] == s[2]) ? s[2] : old;
    endfunction

    always_comb begin
        next_cin.standby_n_input      = settle(sy[0], cin.standby_n_input);
        next_cin.enable               = settle(sy[1], cin.enable);
        next_cin.overcurrent_shutdown = settle(sy[2],
                                               cin.overcurrent_shutdown);
        next_cin.over_temp_shutdown   = settle(sy[3],
                                               cin.over_temp_shutdown);
    end

    // Main sequencer state
    mfl_pkg::mfl_state_e st, next_st;
    logic [W-1:0] cnt, next_cnt;
    logic [W-1:0] lowcnt, next_lowcnt;
    logic ot_latch, next_ot_latch;
    logic oc_latch, next_oc_latch;
    logic en_q, next_en_q;
    logic sb_q, next_sb_q;
    mfl_pkg::mfl_bridge_s br, next_br;
    logic flag_low, next_flag_low;
    logic fault, en_fall, sb_fall, low_done;

    always_comb begin
        next_ot_latch = ot_latch;
        next_oc_latch = oc_latch;
        next_lowcnt   = lowcnt;
        next_st       = st;
        next_cnt      = cnt;
        next_en_q     = cin.enable;
        next_sb_q     = cin.standby_n_input;
        en_fall  = en_q && !cin.enable;
        sb_fall  = sb_q && !cin.standby_n_input && cin.enable;
        low_done = (lowcnt == ENLOW_END);
        // Enable-low timer only runs with the comparator released
        if (cin.enable || cin.over_temp_shutdown
            || cin.overcurrent_shutdown) begin
            next_lowcnt = '0;
        end else if (!low_done) begin
            next_lowcnt = lowcnt + W'(1);
        end
        // Release happens while enable is still low; set wins over clear
        if (!cin.enable && low_done) begin
            if (!cin.over_temp_shutdown) next_ot_latch = 1'b0; // see (R3)
            if (!cin.overcurrent_shutdown) next_oc_latch = 1'b0;
        end
        if (cin.over_temp_shutdown) next_ot_latch = 1'b1; // see (R1)
        if (cin.overcurrent_shutdown) next_oc_latch = 1'b1;
        fault = next_ot_latch || next_oc_latch;
        case (st)
            mfl_pkg::MFL_ST_OFF: begin
                next_cnt = '0;
                if (cin.enable && cin.standby_n_input && !fault) begin
                    next_st = mfl_pkg::MFL_ST_DELAY;
                end
            end
            mfl_pkg::MFL_ST_DELAY: begin
                next_cnt = cnt + W'(1);
                if (fault || !cin.enable || !cin.standby_n_input) begin
                    next_st  = mfl_pkg::MFL_ST_OFF;
                    next_cnt = '0;
                end else if (cnt == DLY_END) begin
                    next_st = mfl_pkg::MFL_ST_ON; // see (R5)
                end
            end
            mfl_pkg::MFL_ST_ON: begin
                next_cnt = '0;
                if (fault || en_fall || sb_fall || !cin.enable) begin
                    next_st = mfl_pkg::MFL_ST_REGEN; // see (R6) (R7) (R8)
                end
            end
            mfl_pkg::MFL_ST_REGEN: begin
                next_cnt = cnt + W'(1);
                if (cnt == REGEN_END) begin
                    next_st  = mfl_pkg::MFL_ST_OFF; // see (R2)
                    next_cnt = '0;
                end
            end
            default: begin
                next_st  = mfl_pkg::MFL_ST_OFF;
                next_cnt = '0;
            end
        endcase
        next_br.drive_on = (next_st == mfl_pkg::MFL_ST_ON);
        next_br.regen    = (next_st == mfl_pkg::MFL_ST_REGEN);
        next_br.hiz      = (next_st == mfl_pkg::MFL_ST_OFF)
                        || (next_st == mfl_pkg::MFL_ST_DELAY);
        next_flag_low    = fault; // see (R1) (R4)
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cin      <= '{default: 1'b0, standby_n_input: 1'b1};
            st       <= mfl_pkg::MFL_ST_OFF;
            cnt      <= '0;
            lowcnt   <= '0;
            ot_latch <= 1'b0;
            oc_latch <= 1'b0;
            en_q     <= 1'b0;
            sb_q     <= 1'b1;
            br       <= '{drive_on: 1'b0, regen: 1'b0, hiz: 1'b1};
            flag_low <= 1'b0;
        end else begin
            cin      <= next_cin;
            st       <= next_st;
            cnt      <= next_cnt;
            lowcnt   <= next_lowcnt;
            ot_latch <= next_ot_latch;
            oc_latch <= next_oc_latch;
            en_q     <= next_en_q;
            sb_q     <= next_sb_q;
            br       <= next_br;
            flag_low <= next_flag_low;
        end
    end

    // Open drain: the pin is only ever pulled low
    assign fault_flag_output_o    = 1'b0;
    assign fault_flag_output_oe_o = flag_low;
    assign bridge_on_o    = br.drive_on;
    assign bridge_regen_o = br.regen;
    assign bridge_hiz_o   = br.hiz;

    // Every check below lives in the one clock domain
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ot_sets_flag: assert property ( // see (R1)
        cin.over_temp_shutdown |=> fault_flag_output_oe_o)
        else $error("over-temperature did not pull flag low");
    a_regen_len: assert property ( // see (R2)
        (st == mfl_pkg::MFL_ST_REGEN && cnt != REGEN_END)
        |=> st == mfl_pkg::MFL_ST_REGEN)
        else $error("regeneration ended early");
    a_regen_end: assert property ( // see (R2)
        (st == mfl_pkg::MFL_ST_REGEN && cnt == REGEN_END)
        |=> st == mfl_pkg::MFL_ST_OFF)
        else $error("regeneration did not end");
    a_latch_hold: assert property ( // see (R3)
        (ot_latch && (cin.enable || !low_done)) |=> ot_latch)
        else $error("latch released without long enable low");
    a_flag_clear: assert property ( // see (R4)
        $fell(ot_latch || oc_latch)
        |-> !fault_flag_output_oe_o && !$past(cin.enable))
        else $error("flag did not rise with release");
    a_on_delay: assert property ( // see (R5)
        (st == mfl_pkg::MFL_ST_DELAY && cnt == DLY_END && cin.enable
         && cin.standby_n_input && !fault) |=> st == mfl_pkg::MFL_ST_ON)
        else $error("bridge did not turn on after delay");
    a_fault_regen: assert property ( // see (R6)
        (st == mfl_pkg::MFL_ST_ON && fault) |=> st == mfl_pkg::MFL_ST_REGEN)
        else $error("fault did not start regeneration");
    a_sb_regen: assert property ( // see (R7)
        (st == mfl_pkg::MFL_ST_ON && sb_fall) |=> bridge_regen_o)
        else $error("standby did not regenerate");
    a_en_regen: assert property ( // see (R8)
        (st == mfl_pkg::MFL_ST_ON && en_fall) |=> st == mfl_pkg::MFL_ST_REGEN)
        else $error("enable fall did not regenerate");
    a_no_on_hiz: assert property (
        !(bridge_on_o && bridge_hiz_o))
        else $error("bridge on and high impedance together");

    c_regen: cover property (
        st == mfl_pkg::MFL_ST_REGEN ##1 st == mfl_pkg::MFL_ST_OFF);
    c_release: cover property (
        $fell(ot_latch));
    c_turn_on: cover property (
        $rose(bridge_on_o));
endmodule

/* bench/mfl_host.sv */
`timescale 1ns/100ps
module mfl_host #(
    parameter int MIN_LOW = 10
) (
    // Clock
    input  wire logic clk_i,
    // Requests from the bench
    input  wire logic en_req_i,
    input  wire logic sb_req_i,
    input  wire logic short_ok_i,
    // Pins towards the device
    output logic      enable_o,
    output logic      standby_n_o
);
    int   low_cnt = 0;
    logic e;
    logic s;
    logic k;
    initial begin
        enable_o = 1'b0;
        standby_n_o = 1'b1;
    end
    // Requests are taken at the edge, pins move a little after it
    always @(posedge clk_i) begin
        e = en_req_i;
        s = sb_req_i;
        k = short_ok_i;
        #1;
        low_cnt = enable_o ? 0 : low_cnt + 1;
        // A short release pulse only goes out when asked for on purpose
        if (e && (low_cnt >= MIN_LOW || k)) enable_o = 1'b1;
        if (!e) enable_o = 1'b0;
        standby_n_o = s;
    end
endmodule

/* bench/tb_mfl_ctrl.sv */
`timescale 1ns/100ps
module tb_mfl_ctrl;
    localparam int REGEN = 20;
    localparam int ENLOW = 10;
    logic clk_i    = 1'b0;
    logic rst_i    = 1'b1;
    logic ot       = 1'b0;
    logic oc       = 1'b0;
    logic en_req   = 1'b0;
    logic sb_req   = 1'b1;
    logic short_ok = 1'b0;
    logic enable;
    logic standby_n;
    logic flag_d;
    logic flag_oe;
    logic on;
    logic regen;
    logic hiz;
    wire  flag_pin = flag_oe ? flag_d : 1'b1;
    int   errors   = 0;
    int   checked  = 0;
    int   cycles   = 0;
    int   seed     = 32'hB9873F45;
    int   n;
    int   cause;
    always #2 clk_i = ~clk_i;
    mfl_host #(.MIN_LOW(ENLOW)) u_host (.clk_i(clk_i), .en_req_i(en_req),
        .sb_req_i(sb_req), .short_ok_i(short_ok), .enable_o(enable),
        .standby_n_o(standby_n));
    mfl_ctrl #(.REGEN_CYCLES(REGEN), .EN_LOW_CYCLES(ENLOW)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .over_temp_shutdown_i(ot),
        .overcurrent_shutdown_i(oc), .enable_i(enable),
        .standby_n_input_i(standby_n), .fault_flag_output_o(flag_d),
        .fault_flag_output_oe_o(flag_oe), .bridge_on_o(on),
        .bridge_regen_o(regen), .bridge_hiz_o(hiz));
    task automatic complete_run();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) begin
            @(posedge clk_i);
            #1;
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_int(input string nm, input int e, input int g);
        checked++;
        if (g != e) begin
            errors++;
            $display("BAD %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // Turn-on time counted from the enable request
    task automatic turn_on();
        int k;
        en_req = 1'b1;
        k = 0;
        while (on !== 1'b1 && k < 2000) begin
            step(1);
            k++;
        end
        chk_bit("on_delay", 1'b1, k >= 1000 && k <= 1012);
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        step(20);
        rst_i = 1'b0;
        step(2);
        chk_bit("hiz_reset", 1'b1, hiz);
        chk_bit("flag_reset", 1'b1, flag_pin);
        turn_on();
        for (int i = 0; i < 9; i++) begin
            cause = (i < 4) ? i : $unsigned($random(seed)) % 4;
            step(1 + $unsigned($random(seed)) % 16);
            case (cause)
                0: ot = 1'b1;
                1: oc = 1'b1;
                2: sb_req = 1'b0;
                default: en_req = 1'b0;
            endcase
            n = 0;
            while (regen !== 1'b1 && n < 10) begin
                step(1);
                n++;
            end
            chk_bit("on_off", 1'b0, on);
            n = 0;
            while (regen === 1'b1 && n < 100) begin
                step(1);
                n++;
            end
            chk_int("regen_cycles", REGEN, n);
            chk_bit("hiz", 1'b1, hiz);
            chk_bit("flag", cause > 1, flag_pin);
            if (cause < 2) begin
                en_req = 1'b0;
                step(ENLOW + 8);
                en_req = 1'b1;
                step(ENLOW);
                chk_bit("flag_hot", 1'b0, flag_pin);
                chk_bit("on_refused", 1'b0, on);
                ot = 1'b0;
                oc = 1'b0;
                short_ok = 1'b1;
                en_req = 1'b0;
                step(ENLOW / 2);
                en_req = 1'b1;
                step(ENLOW);
                short_ok = 1'b0;
                chk_bit("flag_short", 1'b0, flag_pin);
                en_req = 1'b0;
                n = 0;
                while (flag_pin !== 1'b1 && n < ENLOW + 20) begin
                    step(1);
                    n++;
                end
                chk_bit("release_time", 1'b1, n >= ENLOW);
                chk_bit("enable_low", 1'b0, enable);
                step(2);
            end
            sb_req = 1'b1;
            turn_on();
        end
        complete_run();
    end
endmodule
